// ===== common/adccal_pkg.sv
// Constants shared by the calibration control register bank.
// Assumes an 8-bit data, 15-bit address serial control frame.
package adccal_pkg;

    ////////////////////////////////////////////////////////////////////
    // Serial frame layout
    localparam int ADDR_W     = 15;
    localparam int DATA_W     = 8;
    localparam int CNT_W      = 5;
    localparam logic [CNT_W-1:0] CNT_HDR   = 5'h10;
    localparam logic [CNT_W-1:0] CNT_FRAME = 5'h18;
    localparam int HDR_RW_BIT = 15;

    ////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_SETUP_MAIN = 15'h050;
    localparam logic [ADDR_W-1:0] OFS_SIG_RANGE  = 15'h051;
    localparam logic [ADDR_W-1:0] OFS_BG_CTRL    = 15'h057;
    localparam logic [ADDR_W-1:0] OFS_PAT_OVR    = 15'h058;
    localparam logic [ADDR_W-1:0] OFS_CAL_VECTOR = 15'h05a;
    localparam logic [ADDR_W-1:0] OFS_CAL_STATUS = 15'h05b;

    ////////////////////////////////////////////////////////////////////
    // Reset values and fixed status bits
    localparam logic [DATA_W-1:0] RST_SETUP_MAIN = 8'h06;
    localparam logic [DATA_W-1:0] RST_SIG_RANGE  = 8'hf4;
    localparam logic [DATA_W-1:0] RST_BG_CTRL    = 8'h10;
    localparam logic [DATA_W-1:0] RST_PAT_OVR    = 8'h00;
    localparam logic [5:0]        STATUS_RSV     = 6'h02;

    ////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int BIT_TS_EN   = 5;
    localparam int BIT_VEC_EN  = 4;
    localparam int BIT_FG_TRIG = 3;
    localparam int RANGE_MSB   = 6;
    localparam int RANGE_LSB   = 4;
    localparam int BIT_BG_RUN  = 1;
    localparam int BIT_BG_MODE = 0;
    localparam int BIT_PAT_EN  = 2;
    localparam int BIT_OVR_EN  = 1;

    ////////////////////////////////////////////////////////////////////
    // Calibration engine states
    typedef enum logic [1:0] {
        cal_idle,
        cal_fg,
        cal_bg_run,
        cal_bg_stop
    } adccal_state_t;

endpackage : adccal_pkg

// ===== verilog/adccal_serial_port.sv
// Serial control port slave: 24-bit frames, rw flag, address, data.
// Assumes serial clock at most one eighth of clk_i; pins are async.
`timescale 1ns/1ps
module adccal_serial_port
    import adccal_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              sclk_i,
    input  wire logic              cs_n_i,
    input  wire logic              sdi_i,
    input  wire logic [DATA_W-1:0] rdata_i,
    output logic                   wr_stb_o,
    output logic                   rd_stb_o,
    output logic [ADDR_W-1:0]      addr_o,
    output logic [DATA_W-1:0]      wdata_o,
    output logic                   sdo_o,
    output logic                   sdo_oe_o
);

    logic [1:0]       sclk_sync;
    logic [1:0]       cs_sync;
    logic [1:0]       sdi_sync;
    logic             sclk_prev;
    logic [15:0]      hdr;
    logic [CNT_W-1:0] bit_cnt;
    logic             is_read;
    logic             load_pend;
    logic [DATA_W-1:0] tx;

    wire              sclk_rise = sclk_sync[1] & ~sclk_prev;
    wire              sclk_fall = ~sclk_sync[1] & sclk_prev;
    wire              active    = ~cs_sync[1];
    wire              sdi_s     = sdi_sync[1];
    wire [CNT_W-1:0]  next_cnt  = bit_cnt + 5'h01;
    wire [15:0]       next_hdr  = {hdr[14:0], sdi_s};
    wire              out_phase = (bit_cnt > CNT_HDR) &&
                                  (bit_cnt < CNT_FRAME);

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sclk_sync <= 2'h0;
            cs_sync   <= 2'h3;
            sdi_sync  <= 2'h0;
            sclk_prev <= 1'b0;
        end
        else
        begin
            sclk_sync <= {sclk_sync[0], sclk_i};
            cs_sync   <= {cs_sync[0], cs_n_i};
            sdi_sync  <= {sdi_sync[0], sdi_i};
            sclk_prev <= sclk_sync[1];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Frame shifter
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            hdr       <= 16'h0000;
            bit_cnt   <= 5'h00;
            is_read   <= 1'b0;
            load_pend <= 1'b0;
            tx        <= 8'h00;
            addr_o    <= 15'h0000;
            wdata_o   <= 8'h00;
            wr_stb_o  <= 1'b0;
            rd_stb_o  <= 1'b0;
            sdo_o     <= 1'b0;
            sdo_oe_o  <= 1'b0;
        end
        else
        begin
            wr_stb_o  <= 1'b0;
            rd_stb_o  <= 1'b0;
            load_pend <= 1'b0;
            if (!active)
            begin
                bit_cnt  <= 5'h00;
                is_read  <= 1'b0;
                sdo_oe_o <= 1'b0;
            end
            else if (sclk_rise && bit_cnt != CNT_FRAME)
            begin
                bit_cnt <= next_cnt;
                hdr     <= next_hdr;
                if (next_cnt == CNT_HDR)
                begin
                    addr_o    <= next_hdr[ADDR_W-1:0];
                    is_read   <= next_hdr[HDR_RW_BIT];
                    load_pend <= next_hdr[HDR_RW_BIT];
                end
                if (next_cnt == CNT_FRAME && !is_read)
                begin
                    wr_stb_o <= 1'b1;
                    wdata_o  <= next_hdr[DATA_W-1:0];
                end
            end
            else if (load_pend)
            begin
                // Read data is taken once, so side effects fire once
                tx       <= rdata_i;
                sdo_o    <= rdata_i[DATA_W-1];
                sdo_oe_o <= 1'b1;
                rd_stb_o <= 1'b1;
            end
            else if (sclk_fall && is_read && out_phase)
            begin
                tx    <= {tx[DATA_W-2:0], 1'b0};
                sdo_o <= tx[DATA_W-2];
            end
        end
    end

endmodule : adccal_serial_port

// ===== verilog/adccal_ctrl_regs.sv
// Calibration control register bank with its calibration sequencer.
// Assumes a host on the serial control port; all pins asynchronous.
`timescale 1ns/1ps
module adccal_ctrl_regs
    import adccal_pkg::*;
#(
    parameter int FG_CAL_CYCLES   = 256,
    parameter int BG_PASS_CYCLES  = 512,
    parameter int STOP_CYCLES     = 16,
    parameter int VEC_DEPTH       = 16
)
(
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       sclk_i,
    input  wire logic       cs_n_i,
    input  wire logic       sdi_i,
    input  wire logic       timestamp_i,
    output logic            sdo_o,
    output logic            sdo_oe_o,
    output logic            timestamp_capture_o,
    output logic            vector_access_en_o,
    output logic [2:0]      signal_range_select_o,
    output logic            test_pattern_enable_o,
    output logic            overrange_enable_o,
    output logic            bg_mode_o,
    output logic            cal_running_o,
    output logic            cal_done_o,
    output logic            cal_stopped_o
);

    localparam int VI_W = $clog2(VEC_DEPTH);
    localparam logic [15:0] FG_LAST   = 16'(FG_CAL_CYCLES - 1);
    localparam logic [15:0] BG_LAST   = 16'(BG_PASS_CYCLES - 1);
    localparam logic [15:0] STOP_LAST = 16'(STOP_CYCLES - 1);

    logic [1:0]        rst_sync;
    wire               rst_n = rst_sync[1];

    logic              wr_stb;
    logic              rd_stb;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;

    logic [DATA_W-1:0] setup_main;
    logic [DATA_W-1:0] sig_range;
    logic [DATA_W-1:0] bg_ctrl;
    logic [DATA_W-1:0] pat_ovr;
    logic [DATA_W-1:0] vec_mem [VEC_DEPTH];
    logic [VI_W-1:0]   vec_idx;

    logic              fg_pulse;
    logic              fg_pend;
    adccal_state_t     state;
    adccal_state_t     next_state;
    logic [15:0]       cnt;
    logic [15:0]       next_cnt;
    logic              next_done;
    logic [1:0]        ts_sync;

    ////////////////////////////////////////////////////////////////////
    // Reset release
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end

    adccal_serial_port u_port (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n),
        .sclk_i   (sclk_i),
        .cs_n_i   (cs_n_i),
        .sdi_i    (sdi_i),
        .rdata_i  (rdata),
        .wr_stb_o (wr_stb),
        .rd_stb_o (rd_stb),
        .addr_o   (addr),
        .wdata_o  (wdata),
        .sdo_o    (sdo_o),
        .sdo_oe_o (sdo_oe_o)
    );

    ////////////////////////////////////////////////////////////////////
    // Decode
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] ofs);
        return a == ofs;
    endfunction : hit

    wire bg_active = (state == cal_bg_run) || (state == cal_bg_stop);
    wire bg_mode   = bg_ctrl[BIT_BG_MODE];
    wire bg_run    = bg_ctrl[BIT_BG_RUN];
    wire vec_en    = setup_main[BIT_VEC_EN];
    wire wr_setup  = wr_stb && hit(addr, OFS_SETUP_MAIN);
    wire wr_range  = wr_stb && hit(addr, OFS_SIG_RANGE);
    wire wr_bg     = wr_stb && hit(addr, OFS_BG_CTRL);
    wire wr_pat    = wr_stb && hit(addr, OFS_PAT_OVR);
    wire wr_vec    = wr_stb && hit(addr, OFS_CAL_VECTOR);
    wire rd_vec    = rd_stb && hit(addr, OFS_CAL_VECTOR);
    wire vec_step  = vec_en && (wr_vec || rd_vec);
    wire [DATA_W-1:0] status_word = {STATUS_RSV, cal_stopped_o,
                                     cal_done_o};

    assign rdata =
        hit(addr, OFS_SETUP_MAIN) ? setup_main :
        hit(addr, OFS_SIG_RANGE)  ? sig_range  :
        hit(addr, OFS_BG_CTRL)    ? bg_ctrl    :
        hit(addr, OFS_PAT_OVR)    ? pat_ovr    :
        hit(addr, OFS_CAL_VECTOR) ? (vec_en ? vec_mem[vec_idx] : 8'h00) :
        hit(addr, OFS_CAL_STATUS) ? status_word : 8'h00;

    ////////////////////////////////////////////////////////////////////
    // Software registers
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            setup_main <= RST_SETUP_MAIN;
            sig_range  <= RST_SIG_RANGE;
            bg_ctrl    <= RST_BG_CTRL;
            pat_ovr    <= RST_PAT_OVR;
            fg_pulse   <= 1'b0;
        end
        else
        begin
            // Setup and range are frozen while background calibration runs; BG control takes only its run bit
            fg_pulse <= wr_setup && !bg_active && wdata[BIT_FG_TRIG];
            if (wr_setup && !bg_active)
                setup_main <= wdata;
            else if (fg_pulse)
                setup_main[BIT_FG_TRIG] <= 1'b0;
            if (wr_range && !bg_active)
                sig_range <= wdata;
            if (wr_bg && bg_active)
                bg_ctrl[BIT_BG_RUN] <= wdata[BIT_BG_RUN];
            else if (wr_bg)
                bg_ctrl <= wdata;
            if (wr_pat)
                pat_ovr <= wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Calibration vector scan access
    always_ff @(posedge clk_i)
    begin
        if (vec_en && wr_vec)
            vec_mem[vec_idx] <= wdata;
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            vec_idx <= '0;
        else if (!vec_en)
            vec_idx <= '0;
        else if (vec_step)
            vec_idx <= vec_idx + 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    // Calibration sequencer
    always_comb
    begin
        next_state = state;
        next_cnt   = cnt + 16'h0001;
        next_done  = cal_done_o;
        if (fg_pulse)
        begin
            next_state = cal_idle;
            next_cnt   = 16'h0000;
        end
        else
        begin
            case (state)
                cal_idle:
                begin
                    next_cnt = 16'h0000;
                    if (fg_pend)
                        next_state = cal_fg;
                    else if (bg_mode && bg_run)
                        next_state = cal_bg_run;
                end
                cal_fg:
                    if (cnt == FG_LAST)
                    begin
                        next_done  = 1'b1;
                        next_cnt   = 16'h0000;
                        next_state = (bg_mode && bg_run) ? cal_bg_run
                                                         : cal_idle;
                    end
                cal_bg_run:
                    if (!bg_mode || !bg_run)
                    begin
                        next_state = cal_bg_stop;
                        next_cnt   = 16'h0000;
                    end
                    else if (cnt == BG_LAST)
                    begin
                        next_done = 1'b1;
                        next_cnt  = 16'h0000;
                    end
                cal_bg_stop:
                    if (bg_mode && bg_run)
                    begin
                        next_state = cal_bg_run;
                        next_cnt   = 16'h0000;
                    end
                    else if (cnt == STOP_LAST)
                        next_state = cal_idle;
                default:
                    next_state = cal_idle;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state         <= cal_idle;
            cnt           <= 16'h0000;
            fg_pend       <= 1'b0;
            cal_done_o    <= 1'b0;
            cal_running_o <= 1'b0;
            cal_stopped_o <= 1'b1;
        end
        else
        begin
            state         <= next_state;
            cnt           <= next_cnt;
            cal_done_o    <= next_done;
            fg_pend       <= fg_pulse || (fg_pend && state != cal_idle);
            cal_running_o <= next_state != cal_idle;
            cal_stopped_o <= (state == cal_idle) && !fg_pend
                             && !fg_pulse;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs and timestamp capture
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ts_sync             <= 2'h0;
            timestamp_capture_o <= 1'b0;
        end
        else
        begin
            ts_sync             <= {ts_sync[0], timestamp_i};
            timestamp_capture_o <= setup_main[BIT_TS_EN] && ts_sync[1];
        end
    end

    assign vector_access_en_o    = vec_en;
    assign signal_range_select_o = sig_range[RANGE_MSB:RANGE_LSB];
    assign test_pattern_enable_o = pat_ovr[BIT_PAT_EN];
    assign overrange_enable_o    = pat_ovr[BIT_OVR_EN];
    assign bg_mode_o             = bg_mode;

    ////////////////////////////////////////////////////////////////////
    // Checks
    a_fg_self_clear: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        fg_pulse |=> !setup_main[BIT_FG_TRIG] && !fg_pulse)
        else $error("foreground trigger did not self-clear");

    a_fg_restart: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        fg_pulse ##1 !fg_pulse |-> state == cal_idle ##1 state == cal_fg)
        else $error("trigger did not restart foreground run");

    a_done_first: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        state == cal_fg && cnt == FG_LAST && !fg_pulse |=> cal_done_o)
        else $error("done flag missing after foreground run");

    a_bg_start: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        state == cal_idle && !fg_pend && !fg_pulse && bg_mode && bg_run
        |=> state == cal_bg_run ##1 !cal_stopped_o)
        else $error("background run did not start");

    a_bg_pause: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        state == cal_bg_run && !bg_run && !fg_pulse
        |=> state == cal_bg_stop ##1 !cal_stopped_o)
        else $error("pause did not enter stopping phase");

    a_range_lock: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        wr_range && bg_active |=> $stable(sig_range))
        else $error("range changed during background run");

    a_vec_gate: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        (wr_vec || rd_vec) && !vec_en |=> vec_idx == '0)
        else $error("vector access moved while disabled");

    a_pat_write: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        wr_pat |=> test_pattern_enable_o == $past(wdata[BIT_PAT_EN]))
        else $error("test pattern enable not updated");

    a_ts_gate: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        !setup_main[BIT_TS_EN] |=> !timestamp_capture_o)
        else $error("timestamp captured while disabled");

endmodule : adccal_ctrl_regs

// ===== sim/adccal_host.sv
// Serial control host model: sends 24-bit frames, collects read data.
// Assumes the device clock as timebase; signals move on its falling edge.
`timescale 1ns/1ps
module adccal_host
    import adccal_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic sdo_i,
    input  wire logic sdo_oe_i,
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      sdi_o
);
    // Half period of 6 clocks keeps sclk well under clk/8
    localparam int HALF = 6;

    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o  = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_i);
    endtask : wait_clk

    ////////////////////////////////////////////////////////////////////
    // One access a frame; sclk stands low between frames
    // Settings are written before the trigger by the caller
    task automatic xfer(input  logic              rd,
                        input  logic [ADDR_W-1:0] addr,
                        input  logic [DATA_W-1:0] wdat,
                        output logic [DATA_W-1:0] rdat);
        logic [23:0] frame;
        frame  = {rd, addr, wdat};
        rdat   = '0;
        cs_n_o = 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            sdi_o = frame[i];
            wait_clk(HALF);
            sclk_o = 1'b1;
            // Undriven line reads as unknown so it can never match
            if (i < 8)
                rdat[i] = sdo_oe_i ? sdo_i : 1'bx;
            wait_clk(HALF);
            sclk_o = 1'b0;
        end
        wait_clk(2);
        cs_n_o = 1'b1;
        // Released data line no longer shows the last bit
        sdi_o = ~sdi_o;
        wait_clk(8);
    endtask : xfer
endmodule : adccal_host

// ===== sim/test_adccal_ctrl_regs.sv
// Self-checking bench for the calibration control register bank.
// Assumes the host model in adccal_host.sv; link enable lives elsewhere.
`timescale 1ns/1ps
module test_adccal_ctrl_regs;
    import adccal_pkg::*;

    logic       clk_i = 1'b0;
    logic       reset_n_i = 1'b0;
    logic       timestamp_i = 1'b0;
    logic       sclk, cs_n, sdi, sdo_o, sdo_oe_o;
    logic       timestamp_capture_o, vector_access_en_o;
    logic [2:0] signal_range_select_o;
    logic       test_pattern_enable_o, overrange_enable_o, bg_mode_o;
    logic       cal_running_o, cal_done_o, cal_stopped_o;
    int         mismatches = 0;
    int         tests_run = 0;
    int         n;

    always #20 clk_i = ~clk_i;

    adccal_ctrl_regs #(.FG_CAL_CYCLES(8), .BG_PASS_CYCLES(8),
                       .STOP_CYCLES(2), .VEC_DEPTH(4)) u_dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .sclk_i(sclk),
        .cs_n_i(cs_n), .sdi_i(sdi), .timestamp_i(timestamp_i),
        .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
        .timestamp_capture_o(timestamp_capture_o),
        .vector_access_en_o(vector_access_en_o),
        .signal_range_select_o(signal_range_select_o),
        .test_pattern_enable_o(test_pattern_enable_o),
        .overrange_enable_o(overrange_enable_o), .bg_mode_o(bg_mode_o),
        .cal_running_o(cal_running_o), .cal_done_o(cal_done_o),
        .cal_stopped_o(cal_stopped_o));

    adccal_host u_host (
        .clk_i(clk_i), .sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o),
        .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi));

    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        logic [7:0] dummy;
        u_host.xfer(1'b0, a, d, dummy);
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        logic [7:0] got;
        u_host.xfer(1'b1, a, 8'h00, got);
        check(got, exp);
    endtask : rd

    // Link enable lives in another block; this bank must ignore it
    localparam logic [ADDR_W-1:0] LINK_CTRL = 15'h201;
    localparam logic [7:0]        LINK_ON   = 8'h01;

    task automatic relink;
        wr(LINK_CTRL, 8'h00);
        wr(LINK_CTRL, LINK_ON);
        rd(LINK_CTRL, 8'h00);
    endtask : relink

    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test

    // Whole run is near 13000 clocks; a hang is cut off well after
    initial
    begin
        repeat (40000) @(posedge clk_i);
        mismatches++;
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (3) @(negedge clk_i);
        reset_n_i = 1'b1;
        repeat (10) @(negedge clk_i);
        check({5'h0, signal_range_select_o}, 8'h07);
        check({6'h0, cal_stopped_o, cal_done_o}, 8'h02);
        rd(OFS_SETUP_MAIN, 8'h06);
        rd(OFS_SIG_RANGE, 8'hf4);
        rd(OFS_BG_CTRL, 8'h10);
        rd(OFS_PAT_OVR, 8'h00);
        // Large-signal range, reserved bits written back unchanged
        wr(OFS_SIG_RANGE, 8'h84);
        rd(OFS_SIG_RANGE, 8'h84);
        check({5'h0, signal_range_select_o}, 8'h00);
        wr(OFS_PAT_OVR, 8'h06);
        rd(OFS_PAT_OVR, 8'h06);
        check({6'h0, test_pattern_enable_o, overrange_enable_o},
              8'h03);
        // Timestamp capture and vector access
        wr(OFS_SETUP_MAIN, 8'h36);
        timestamp_i = 1'b1;
        repeat (6) @(negedge clk_i);
        check({6'h0, timestamp_capture_o, vector_access_en_o}, 8'h03);
        timestamp_i = 1'b0;
        repeat (6) @(negedge clk_i);
        check({7'h0, timestamp_capture_o}, 8'h00);
        for (int i = 0; i < 4; i++)
            wr(OFS_CAL_VECTOR, 8'(8'h11 * (i + 1)));
        for (int i = 0; i < 4; i++)
            rd(OFS_CAL_VECTOR, 8'(8'h11 * (i + 1)));
        wr(OFS_SETUP_MAIN, 8'h26);
        rd(OFS_CAL_VECTOR, 8'h00);
        check({6'h0, timestamp_capture_o, vector_access_en_o}, 8'h00);
        // Foreground calibration: trigger clears itself
        check({7'h0, cal_done_o}, 8'h00);
        wr(OFS_SETUP_MAIN, 8'h0e);
        relink();
        rd(OFS_SETUP_MAIN, 8'h06);
        check({7'h0, cal_done_o}, 8'h01);
        rd(OFS_CAL_STATUS, 8'h0b);
        // Background run; the range field is locked meanwhile
        wr(OFS_BG_CTRL, 8'h13);
        check({5'h0, bg_mode_o, cal_running_o, cal_stopped_o},
              8'h06);
        wr(OFS_SIG_RANGE, 8'hf4);
        rd(OFS_SIG_RANGE, 8'h84);
        rd(OFS_CAL_STATUS, 8'h09);
        // Pause keeps the mode bit; wait for the stopped flag
        wr(OFS_BG_CTRL, 8'h11);
        for (n = 0; n < 100 && cal_stopped_o !== 1'b1; n++)
            @(negedge clk_i);
        check({6'h0, bg_mode_o, cal_stopped_o}, 8'h03);
        rd(OFS_BG_CTRL, 8'h11);
        wr(OFS_SIG_RANGE, 8'hf4);
        rd(OFS_SIG_RANGE, 8'hf4);
        check({5'h0, signal_range_select_o}, 8'h07);
        // Mode cleared, then a fresh foreground pass
        wr(OFS_BG_CTRL, 8'h10);
        wr(OFS_SETUP_MAIN, 8'h0e);
        relink();
        rd(OFS_CAL_STATUS, 8'h0b);
        // Unmapped and read-only places
        wr(15'h059, 8'hff);
        rd(15'h059, 8'h00);
        wr(OFS_CAL_STATUS, 8'h00);
        rd(OFS_CAL_STATUS, 8'h0b);
        finish_test();
    end
endmodule : test_adccal_ctrl_regs
